/* File: hdl/spi_cmd_regs.svh */
`ifndef SPI_CMD_REGS_SVH
`define SPI_CMD_REGS_SVH

// Frame and command layout
`define FRAME_BITS 16
`define CMD_OPC_HI 7
`define CMD_OPC_LO 6
`define CMD_ADDR_HI 5

// Global status bit positions
`define GS_UNUSED 0
`define GS_OVERCURRENT 1
`define GS_OPENLOAD 2
`define GS_TEMPWARN 3
`define GS_THERMAL 4
`define GS_CHIPRESET 5
`define GS_COMMERR 6
`define GS_SUMMARY 7

// RAM map
`define ADDR_CTRL0 6'h00
`define ADDR_CTRL1 6'h01
`define ADDR_CTRL2 6'h02
`define ADDR_STAT0 6'h04
`define ADDR_STAT1 6'h05
`define ADDR_CONFIG 6'h3F

// Reset values
`define CTRL0_RST 8'h00
`define CTRL1_RST 8'h80
`define CTRL2_RST 8'h00

// ROM map and contents
`define ROM_ADDR_HDR 6'h00
`define ROM_ADDR_PROD 6'h01
`define ROM_ADDR_VER 6'h02
`define ROM_ADDR_FRAME 6'h3E
`define ROM_FRAME_ID 8'h01

`endif

/* File: hdl/spi_cmd_pkg.sv */
`default_nettype none
package spi_cmd_pkg;
    // Operation codes of the command byte
    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_READ = 2'b01,
        OP_READ_CLEAR = 2'b10,
        OP_READ_INFO = 2'b11
    } opcode_t;

    // Frame progress of the shift logic
    typedef enum logic [1:0] {
        FR_IDLE,
        FR_CMD,
        FR_DATA,
        FR_OVER
    } frame_t;
endpackage

`default_nettype wire

/* File: hdl/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// Two flip-flop synchroniser, one per bit
module pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] rst_val,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Second stage alone reads the first
            always_ff @(posedge clk) begin
                if (srst) begin
                    meta_ff[i] <= rst_val[i];
                    sync_ff[i] <= rst_val[i];
                end else begin
                    meta_ff[i] <= async_in[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_ff;
endmodule

`default_nettype wire

/* File: hdl/spi_slave_cmd.sv */
`timescale 1ns/1ns
`default_nettype none
`include "spi_cmd_regs.svh"

// Contract
// - Sample serial input on rising serial clock while chip select is low.
// - Move serial output to next bit on each falling serial clock.
// - Chip select high deselects device; output held high impedance.
// - Selected, before any edge, output shows summary error flag bit 7.
// - One frame is 16 bits: command byte then data byte, MSB first.
// - Global status byte shifts out first, during command reception.
// - Write frame returns the register value before the write.
// - Read frame returns current content of addressed register.
// - Command byte: two opcode bits on top, six address bits below.
// - Opcodes: 00 write, 01 read, 10 read and clear, 11 ROM read.
// - Read and clear returns status register content then clears it.
// - Read and clear at address 3FH clears all status registers.
// - Read and clear on unused or control address acts as read; unused 00H.
// - ROM read gives family, product, version and register width; the code holds no width, and 3EH gives frame ID 01H.
// - Status bit 1 set on overcurrent; bit 0 always reads zero.
// - Bit 2 open load, 3 warning, 4 shutdown, 5 chip reset, 6 comm error.
// - Wrong clock count in frame discards writes and flags comm error.
// - Summary flag is OR of all other failure bits.
// - Chip reset bit clears at first valid frame after internal reset.

module spi_slave_cmd
    import spi_cmd_pkg::*;
#(
    parameter logic [7:0] ROM_HEADER = 8'h5A, // Arbitrary identity value
    parameter logic [7:0] ROM_PRODUCT = 8'h11, // Arbitrary identity value
    parameter logic [7:0] ROM_VERSION = 8'h22 // Arbitrary identity value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial link pins
    input wire logic sclk,
    input wire logic chipSelectN,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEnN,
    // Channel fault and reset events as one-cycle pulses, temperature faults as levels
    input wire logic [5:0] overcurrentEvt,
    input wire logic [5:0] openLoadEvt,
    input wire logic tempWarnLvl,
    input wire logic thermalShutLvl,
    input wire logic internalResetEvt,
    // Control register contents
    output logic [7:0] ctrl0,
    output logic [7:0] ctrl1,
    output logic [7:0] ctrl2
);
    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    logic [2:0] pinSync;
    logic sclkSync;
    logic chipSelectLowN;
    logic dinSync;
    logic sclkPrev_ff;
    logic csPrev_ff;

    // Reset values equal the idle pins, so no false edge follows reset
    pin_sync #(.WIDTH(3)) u_sync (
        .clk(clk),
        .srst(srst),
        .async_in({sclk, chipSelectN, serialIn}),
        .rst_val(3'b010),
        .sync_out(pinSync)
    );

    assign sclkSync = pinSync[2];
    assign chipSelectLowN = pinSync[1];
    assign dinSync = pinSync[0];

    // Previous values for edge finding
    always_ff @(posedge clk) begin
        if (srst) begin
            sclkPrev_ff <= 1'b0;
            csPrev_ff <= 1'b1;
        end else begin
            sclkPrev_ff <= sclkSync;
            csPrev_ff <= chipSelectLowN;
        end
    end

    logic selected;
    logic sclkRise;
    logic sclkFall;
    logic frameStart;
    logic frameEnd;
    assign selected = ~chipSelectLowN;
    assign sclkRise = selected & sclkSync & ~sclkPrev_ff;
    assign sclkFall = selected & ~sclkSync & sclkPrev_ff;
    assign frameStart = csPrev_ff & ~chipSelectLowN;
    assign frameEnd = ~csPrev_ff & chipSelectLowN;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] ctrl0_ff;
    logic [7:0] ctrl1_ff;
    logic [7:0] ctrl2_ff;
    logic [7:0] stat0_ff;
    logic [7:0] stat1_ff;
    logic [5:0] gsFlags_ff; // Global bits 1..6
    logic [7:0] globalStatus;

    // Summary flag is OR of bits 1..6, bit 0 stays zero
    assign globalStatus = {|gsFlags_ff, gsFlags_ff, 1'b0};

    assign ctrl0 = ctrl0_ff;
    assign ctrl1 = ctrl1_ff;
    assign ctrl2 = ctrl2_ff;

    // ------------------------------------------------------------
    // Serial shift logic
    // ------------------------------------------------------------
    logic [4:0] bitCnt_ff;
    logic [7:0] cmd_ff;
    logic [6:0] dataIn_ff;
    logic [7:0] shiftOut_ff;
    logic outBit_ff;
    logic outEnN_ff;
    frame_t frame_ff;
    frame_t nxt_frame;

    // Command fields
    opcode_t opcode;
    logic [5:0] addr;
    assign opcode = opcode_t'(cmd_ff[`CMD_OPC_HI:`CMD_OPC_LO]);
    assign addr = cmd_ff[`CMD_ADDR_HI:0];

    // Fields of the command being completed on this rising edge
    logic [7:0] cmdNow;
    assign cmdNow = {cmd_ff[6:0], dinSync};

    // RAM and ROM read selection for the reply byte
    logic [7:0] ramRead;
    logic [7:0] romRead;
    logic [7:0] replyByte;
    logic [5:0] cmdAddr;
    logic cmdRom;
    assign cmdAddr = cmdNow[`CMD_ADDR_HI:0];
    assign cmdRom = (cmdNow[`CMD_OPC_HI:`CMD_OPC_LO] == OP_READ_INFO);
    assign ramRead = (cmdAddr == `ADDR_CTRL0) ? ctrl0_ff :
                     (cmdAddr == `ADDR_CTRL1) ? ctrl1_ff :
                     (cmdAddr == `ADDR_CTRL2) ? ctrl2_ff :
                     (cmdAddr == `ADDR_STAT0) ? stat0_ff :
                     (cmdAddr == `ADDR_STAT1) ? stat1_ff :
                     8'h00;
    assign romRead = (cmdAddr == `ROM_ADDR_HDR) ? ROM_HEADER :
                     (cmdAddr == `ROM_ADDR_PROD) ? ROM_PRODUCT :
                     (cmdAddr == `ROM_ADDR_VER) ? ROM_VERSION :
                     (cmdAddr == `ROM_ADDR_FRAME) ? `ROM_FRAME_ID :
                     8'h00;
    // Read reply; a write reply is the pre-write value, same mux
    assign replyByte = cmdRom ? romRead : ramRead;

    // Frame progress
    // Deselect always wins, so a cut frame restarts from idle
    always_comb begin
        nxt_frame = frame_ff;
        case (frame_ff)
            FR_IDLE: begin
                if (frameStart) begin
                    nxt_frame = FR_CMD;
                end
            end
            FR_CMD: begin
                if (sclkRise && bitCnt_ff == 5'd7) begin
                    nxt_frame = FR_DATA;
                end
            end
            FR_DATA: begin
                if (sclkRise && bitCnt_ff == 5'(`FRAME_BITS - 1)) begin
                    nxt_frame = FR_OVER;
                end
            end
            FR_OVER: begin
                nxt_frame = frame_ff;
            end
            default: begin
                nxt_frame = FR_IDLE;
            end
        endcase
        if (!selected) begin
            nxt_frame = FR_IDLE;
        end
    end

    // Bit counter, saturating past the frame length
    // Saturation keeps an overlong frame from wrapping back to sixteen
    always_ff @(posedge clk) begin
        if (srst || !selected) begin
            bitCnt_ff <= 5'd0;
        end else if (sclkRise && bitCnt_ff != 5'h1F) begin
            bitCnt_ff <= bitCnt_ff + 5'd1;
        end
    end

    // Input shifting, MSB first
    always_ff @(posedge clk) begin
        if (srst) begin
            frame_ff <= FR_IDLE;
            cmd_ff <= 8'h00;
            dataIn_ff <= 7'h00;
        end else begin
            frame_ff <= nxt_frame;
            if (sclkRise && frame_ff == FR_CMD) begin
                cmd_ff <= cmdNow;
            end else if (sclkRise && frame_ff == FR_DATA
                         && bitCnt_ff != 5'(`FRAME_BITS - 1)) begin
                // Upper seven data bits; the last lands in lastBit_ff
                dataIn_ff <= {dataIn_ff[5:0], dinSync};
            end
        end
    end

    // Output stage: status byte, then reply, then zero fill
    // Reply is loaded on the eighth rise, once the address is whole
    always_ff @(posedge clk) begin
        if (srst || !selected) begin
            outEnN_ff <= 1'b1;
            outBit_ff <= 1'b0;
            shiftOut_ff <= 8'h00;
        end else if (frameStart) begin
            outEnN_ff <= 1'b0;
            outBit_ff <= globalStatus[`GS_SUMMARY];
            shiftOut_ff <= {globalStatus[6:0], 1'b0};
        end else if (sclkRise && frame_ff == FR_CMD && bitCnt_ff == 5'd7) begin
            shiftOut_ff <= replyByte;
        end else if (sclkFall) begin
            outBit_ff <= shiftOut_ff[7];
            shiftOut_ff <= {shiftOut_ff[6:0], 1'b0};
        end
    end

    assign serialOut = outBit_ff;
    assign serialOutEnN = outEnN_ff;

    // ------------------------------------------------------------
    // End-of-frame actions
    // ------------------------------------------------------------
    logic frameGood;
    logic commitWrite;
    logic commitClear;
    logic clearAll;
    // Length is judged from the count before deselect clears it
    assign frameGood = frameEnd && bitCnt_ff == 5'(`FRAME_BITS);
    logic [7:0] fullData;
    logic lastBit_ff;
    assign fullData = {dataIn_ff, lastBit_ff};
    assign commitWrite = frameGood && opcode == OP_WRITE;
    assign commitClear = frameGood && opcode == OP_READ_CLEAR;
    assign clearAll = commitClear && addr == `ADDR_CONFIG;

    // Last data bit is caught on the sixteenth rising edge
    always_ff @(posedge clk) begin
        if (srst) begin
            lastBit_ff <= 1'b0;
        end else if (sclkRise && frame_ff == FR_DATA) begin
            lastBit_ff <= dinSync;
        end
    end

    // Control registers; writes only on a full-length frame
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl0_ff <= `CTRL0_RST;
            ctrl1_ff <= `CTRL1_RST;
            ctrl2_ff <= `CTRL2_RST;
        end else if (commitWrite) begin
            if (addr == `ADDR_CTRL0) begin
                ctrl0_ff <= fullData;
            end
            if (addr == `ADDR_CTRL1) begin
                ctrl1_ff <= fullData;
            end
            if (addr == `ADDR_CTRL2) begin
                ctrl2_ff <= fullData;
            end
        end
    end

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    // Channel status registers; a new event wins over the clear
    // Clears act on the closing edge of a good frame only
    logic clrStat0;
    logic clrStat1;
    assign clrStat0 = clearAll || (commitClear && addr == `ADDR_STAT0);
    assign clrStat1 = clearAll || (commitClear && addr == `ADDR_STAT1);
    logic [7:0] stat0Set;
    logic [7:0] stat1Set;
    assign stat0Set = {thermalShutLvl, tempWarnLvl, openLoadEvt};
    assign stat1Set = {thermalShutLvl, tempWarnLvl, overcurrentEvt};

    always_ff @(posedge clk) begin
        if (srst) begin
            stat0_ff <= 8'h00;
            stat1_ff <= 8'h00;
        end else begin
            stat0_ff <= (clrStat0 ? 8'h00 : stat0_ff) | stat0Set;
            stat1_ff <= (clrStat1 ? 8'h00 : stat1_ff) | stat1Set;
        end
    end

    // ------------------------------------------------------------
    // Global status byte
    // ------------------------------------------------------------
    // Global status flags
    logic commErrSet;
    logic commErrClr;
    logic chipRstClr;
    assign commErrSet = frameEnd && !frameGood;
    assign commErrClr = frameGood;
    assign chipRstClr = frameGood;

    always_ff @(posedge clk) begin
        if (srst) begin
            gsFlags_ff <= 6'b01_0000; // Chip reset shown after reset
        end else begin
            // Overcurrent and open-load follow the channel status
            gsFlags_ff[`GS_OVERCURRENT-1] <= |stat1_ff[5:0];
            gsFlags_ff[`GS_OPENLOAD-1] <= |stat0_ff[5:0];
            gsFlags_ff[`GS_TEMPWARN-1] <= stat0_ff[6] | stat1_ff[6];
            gsFlags_ff[`GS_THERMAL-1] <= stat0_ff[7] | stat1_ff[7];
            gsFlags_ff[`GS_CHIPRESET-1] <= internalResetEvt |
                (gsFlags_ff[`GS_CHIPRESET-1] & ~chipRstClr);
            gsFlags_ff[`GS_COMMERR-1] <= commErrSet |
                (gsFlags_ff[`GS_COMMERR-1] & ~commErrClr);
        end
    end

endmodule

`default_nettype wire

/* File: bench/spi_slave_cmd_chk.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Serial link checker
// ----------------------------------------
module spi_slave_cmd_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial pins
    input wire logic sclk,
    input wire logic chipSelectN,
    input wire logic serialOut,
    input wire logic serialOutEnN,
    // Fault levels and control registers
    input wire logic tempWarnLvl,
    input wire logic thermalShutLvl,
    input wire logic [7:0] ctrl0,
    input wire logic [7:0] ctrl1,
    input wire logic [7:0] ctrl2
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);

    // Reset leaves the pin released and controls at defaults
    property p_rstVals;
        $fell(srst) |-> serialOutEnN && ctrl0 == 8'h00
            && ctrl1 == 8'h80 && ctrl2 == 8'h00;
    endproperty
    property p_hiz;
        chipSelectN [*6] |-> serialOutEnN;
    endproperty
    property p_offQuick;
        $rose(chipSelectN) |-> ##[2:5] serialOutEnN;
    endproperty
    property p_enOn;
        $fell(chipSelectN) |-> ##[2:5] !serialOutEnN;
    endproperty
    property p_enHold;
        !chipSelectN [*6] |-> !serialOutEnN;
    endproperty
    // Output may only move after a falling serial clock
    property p_doStable;
        sclk [*3] |-> $stable(serialOut);
    endproperty
    // Writes land only once the frame is closed
    property p_ctrlHold;
        !chipSelectN [*6] |-> $stable(ctrl0) && $stable(ctrl1)
            && $stable(ctrl2);
    endproperty
    // Standing faults show as summary flag before any clock
    property p_gef;
        (tempWarnLvl && thermalShutLvl && chipSelectN) ##1
            $fell(chipSelectN) |-> ##5 (!serialOutEnN && serialOut);
    endproperty

    a_rstVals: assert property (p_rstVals)
        else $error("reset values wrong");
    a_hiz: assert property (p_hiz)
        else $error("output driven while deselected");
    a_offQuick: assert property (p_offQuick)
        else $error("output not released after frame");
    a_enOn: assert property (p_enOn)
        else $error("output not enabled after select");
    a_enHold: assert property (p_enHold)
        else $error("output dropped while selected");
    a_doStable: assert property (p_doStable)
        else $error("output moved while clock high");
    a_ctrlHold: assert property (p_ctrlHold)
        else $error("control changed inside frame");
    a_gef: assert property (p_gef)
        else $error("summary flag not shown");

    c_frame: cover property ($fell(chipSelectN));
    c_write: cover property ($changed(ctrl0));
    c_fault: cover property ($rose(thermalShutLvl));
endmodule

bind spi_slave_cmd spi_slave_cmd_chk u_chk (
    .clk(clk), .srst(srst), .sclk(sclk), .chipSelectN(chipSelectN),
    .serialOut(serialOut), .serialOutEnN(serialOutEnN),
    .tempWarnLvl(tempWarnLvl), .thermalShutLvl(thermalShutLvl),
    .ctrl0(ctrl0), .ctrl1(ctrl1), .ctrl2(ctrl2)
);

`default_nettype wire

/* File: bench/spi_master_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Bus master model, clock idle low
// ----------------------------------------
module spi_master_model (
    // System clock for pacing
    input wire logic clk,
    // Serial pins
    output logic sclk,
    output logic chipSelectN,
    output logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEnN
);
    initial begin
        sclk = 1'b0;
        chipSelectN = 1'b1;
        serialIn = 1'b0;
    end

    // One frame of n clocks, 320 ns clock period, MSB first
    task automatic xfer(input logic [15:0] tx, input int n,
                        output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clk);
        chipSelectN = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            serialIn = tx[15-i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            rx = {rx[14:0], serialOutEnN ? 1'bx : serialOut};
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        chipSelectN = 1'b1;
        serialIn = 1'b0; // Pulled down once released
        repeat (10) @(negedge clk);
    endtask
endmodule

`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench
    import spi_cmd_pkg::*;
;
    logic clk, srst, sclk, chipSelectN, serialIn, serialOut, serialOutEnN;
    logic tempWarnLvl, thermalShutLvl, internalResetEvt;
    logic [5:0] overcurrentEvt, openLoadEvt;
    logic [7:0] ctrl0, ctrl1, ctrl2;
    logic [15:0] rx;
    int errors = 0;
    int compares = 0;
    // Arbitrary identity values
    localparam logic [7:0] ID_HDR = 8'h6B;
    localparam logic [7:0] ID_PROD = 8'h2D;
    localparam logic [7:0] ID_VER = 8'h4E;
    logic [5:0] romAdr [5] = '{6'h00, 6'h01, 6'h02, 6'h3E, 6'h10};
    logic [7:0] romVal [5] = '{ID_HDR, ID_PROD, ID_VER, 8'h01, 8'h00};

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    spi_slave_cmd #(.ROM_HEADER(ID_HDR), .ROM_PRODUCT(ID_PROD),
        .ROM_VERSION(ID_VER)) u_dut (
        .clk(clk), .srst(srst), .sclk(sclk), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .serialOut(serialOut),
        .serialOutEnN(serialOutEnN), .overcurrentEvt(overcurrentEvt),
        .openLoadEvt(openLoadEvt), .tempWarnLvl(tempWarnLvl),
        .thermalShutLvl(thermalShutLvl),
        .internalResetEvt(internalResetEvt),
        .ctrl0(ctrl0), .ctrl1(ctrl1), .ctrl2(ctrl2));

    spi_master_model u_mst (.clk(clk), .sclk(sclk),
        .chipSelectN(chipSelectN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEnN(serialOutEnN));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask

    // Full frame, reply is status byte then data byte
    task automatic frame(input opcode_t op, input logic [5:0] adr,
                         input logic [7:0] dat, input logic [15:0] exp);
        u_mst.xfer({op, adr, dat}, 16, rx);
        chk($sformatf("reply %h", {op, adr}), rx, exp);
    endtask

    task automatic end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #400000;
        errors++;
        end_sim();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        tempWarnLvl = 1'b0;
        thermalShutLvl = 1'b0;
        internalResetEvt = 1'b0;
        overcurrentEvt = 6'h00;
        openLoadEvt = 6'h00;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        chk("enN", {15'h0000, serialOutEnN}, 16'h0001);
        chk("ctrl01", {ctrl0, ctrl1}, 16'h0080);
        chk("ctrl2", {8'h00, ctrl2}, 16'h0000);
        $display("test reset done");
        frame(OP_READ_INFO, 6'h3E, 8'h00, 16'hA001);
        frame(OP_WRITE, 6'h00, 8'hA5, 16'h0000);
        chk("ctrl0", {8'h00, ctrl0}, 16'h00A5);
        frame(OP_READ, 6'h00, 8'h00, 16'h00A5);
        frame(OP_READ, 6'h01, 8'h00, 16'h0080);
        frame(OP_WRITE, 6'h00, 8'h3C, 16'h00A5);
        $display("test write read done");
        for (int i = 0; i < 5; i++) begin
            frame(OP_READ_INFO, romAdr[i], 8'h00, {8'h00, romVal[i]});
        end
        frame(OP_READ, 6'h03, 8'hFF, 16'h0000);
        frame(OP_READ_CLEAR, 6'h03, 8'h00, 16'h0000);
        $display("test info area done");
        @(negedge clk);
        openLoadEvt = 6'h01;
        overcurrentEvt = 6'h04;
        @(negedge clk);
        openLoadEvt = 6'h00;
        overcurrentEvt = 6'h00;
        repeat (4) @(negedge clk);
        frame(OP_READ_CLEAR, 6'h04, 8'h00, 16'h8601);
        frame(OP_READ, 6'h04, 8'h00, 16'h8200);
        frame(OP_READ, 6'h05, 8'h00, 16'h8204);
        frame(OP_READ_CLEAR, 6'h3F, 8'h00, 16'h8200);
        frame(OP_READ, 6'h05, 8'h00, 16'h0000);
        $display("test status clear done");
        u_mst.xfer({OP_WRITE, 6'h02, 8'hFF}, 8, rx);
        chk("short", rx, 16'h0000);
        frame(OP_READ, 6'h02, 8'h00, 16'hC000);
        frame(OP_READ, 6'h02, 8'h00, 16'h0000);
        $display("test short frame done");
        @(negedge clk);
        internalResetEvt = 1'b1;
        @(negedge clk);
        internalResetEvt = 1'b0;
        repeat (4) @(negedge clk);
        frame(OP_READ, 6'h00, 8'h00, 16'hA03C);
        tempWarnLvl = 1'b1;
        thermalShutLvl = 1'b1;
        repeat (5) @(negedge clk);
        frame(OP_READ, 6'h04, 8'h00, 16'h98C0);
        $display("test fault flags done");
        end_sim();
    end
endmodule

`default_nettype wire
